/* File: hdl/pa_consts.svh */
`ifndef PA_CONSTS_SVH
`define PA_CONSTS_SVH

`define PA_ADDR_W 12
`define PA_DATA_W 32

`define PA_OFF_LEVEL 12'h000
`define PA_OFF_LATCH 12'h004
`define PA_OFF_DIR 12'h008
`define PA_OFF_ANALOG 12'h00C
`define PA_OFF_CMP 12'h010
`define PA_OFF_REF 12'h014
`define PA_OFF_OSC 12'h018
`define PA_OFF_STATUS 12'h01C

`define PA_RST_LATCH 8'h00
`define PA_RST_DIR 8'hFF
`define PA_RST_ANALOG 8'h2F
`define PA_RST_CMP_OFF 1'b1
`define PA_RST_OSC PA_OSC_INTERNAL_OSC_IO_VARIANT_TWO

`define PA_ANALOG_MASK 8'h2F
`define PA_CMP_PINS 8'h0F
`define PA_COMPARATOR_REFERENCE_OUTPUT_PIN 8'h04
`define PA_LOW_PORT 6'h3F

`define PA_PIN_T0 4
`define PA_PIN_SS 5
`define PA_PIN_CYCLE_CLOCK_OUTPUT 6

`define PA_CMP_OFF_BIT 0
`define PA_CMP_C1OE_BIT 1
`define PA_CMP_C2OE_BIT 2
`define PA_REF_OE_BIT 0
`define PA_OSC_W 4
`define PA_OSC_COUNT 4'h9

`endif

/* File: hdl/pa_pkg.sv */
`include "pa_consts.svh"

package pa_pkg;

   typedef enum logic [`PA_OSC_W-1:0] {
      PA_OSC_LP,
      PA_OSC_XT,
      PA_OSC_HS,
      PA_OSC_RC,
      PA_OSC_RESISTOR_CAPACITOR_IO_MODE,
      PA_OSC_EC,
      PA_OSC_EXTERNAL_CLOCK_IO_MODE,
      PA_OSC_INTERNAL_OSC_CLOCKOUT_VARIANT_ONE,
      PA_OSC_INTERNAL_OSC_IO_VARIANT_TWO
   } pa_osc_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`PA_ADDR_W-1:0] paddr;
      logic [`PA_DATA_W-1:0] pwdata;
      logic [3:0] pstrb;
   } pa_apb_req_type;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [`PA_DATA_W-1:0] prdata;
   } pa_apb_rsp_type;

   typedef struct packed {
      logic [7:0] pin_out;
      logic [7:0] pin_oe_n;
   } pa_pins_type;

endpackage

/* File: hdl/pa_port.sv */
// What this block does
// - Eight pins: direction, latch, level each.
// - Direction one floats the pin driver.
// - Direction zero drives the latch value.
// - Port reads pins; port writes latch.
// - Latch register reads back latched values.
// - Oscillator setting picks pins six/seven role.
// - Non-port pins six/seven read zero in level, latch and direction.
// - Pin six I/O only in I/O modes.
// - Clock-out modes drive quarter clock on six.
// - Pin seven I/O off in external modes.
// - Converter control picks analog pins 0-3,5.
// - Analog pin: digital input off, reads zero.
// - Analog pin still drives latch as output.
// - Reset: pins 0-3,5 analog, pin four digital.
// - Pins 0-3 digital input needs comparators off.
// - Comparator one result overrides pin four.
// - Comparator two result overrides pin five.
// - Reference output disables pin two I/O.
// - Direction still rules drivers on analog pins.
// - Pin four feeds timer; five feeds select.
`include "pa_consts.svh"

module pa_port (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire pa_pkg::pa_apb_req_type apb_req,
   output pa_pkg::pa_apb_rsp_type apb_rsp,
   input wire logic [7:0] pin_in,
   output pa_pkg::pa_pins_type pins,
   input wire logic comparator_one_result,
   input wire logic comparator_two_result,
   input wire logic quarter_clock,
   output logic timer_zero_clock_in,
   output logic slave_select_in_n
);
   import pa_pkg::*;

   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] dir;
      logic [7:0] analog;
      logic cmp_off;
      logic c1_oe;
      logic c2_oe;
      logic comparator_reference_output_oe;
      pa_osc_type osc;
      logic [7:0] sync1;
      logic [7:0] sync2;
      pa_apb_rsp_type rsp;
      pa_pins_type pins;
      logic t0_clk;
      logic ss_n;
   } pa_state_type;

   pa_state_type s;
   pa_state_type next_s;

   logic [7:0] port_mask;
   logic [7:0] din_en;
   logic [7:0] nx_port_mask;
   logic [7:0] nx_drive;
   logic [7:0] nx_value;
   logic [`PA_DATA_W-1:0] rd_data;
   logic mapped;
   logic setup;
   logic wr_take;
   logic [`PA_OSC_W-1:0] osc_code;

   function automatic logic pin6_io(input pa_osc_type m);
      pin6_io = (m == PA_OSC_RESISTOR_CAPACITOR_IO_MODE) || (m == PA_OSC_INTERNAL_OSC_IO_VARIANT_TWO) || (m == PA_OSC_EXTERNAL_CLOCK_IO_MODE);
   endfunction

   function automatic logic pin6_cycle_clock_output(input pa_osc_type m);
      pin6_cycle_clock_output = (m == PA_OSC_RC) || (m == PA_OSC_INTERNAL_OSC_CLOCKOUT_VARIANT_ONE) || (m == PA_OSC_EC);
   endfunction

   function automatic logic pin7_io(input pa_osc_type m);
      pin7_io = (m == PA_OSC_INTERNAL_OSC_CLOCKOUT_VARIANT_ONE) || (m == PA_OSC_INTERNAL_OSC_IO_VARIANT_TWO);
   endfunction

   // Pins that the comparators or the reference may claim
   localparam logic [7:0] CMP_SET = `PA_CMP_PINS;
   localparam logic [7:0] REF_SET = `PA_COMPARATOR_REFERENCE_OUTPUT_PIN;

   // Port role from the current mode
   assign port_mask = {pin7_io(s.osc), pin6_io(s.osc), `PA_LOW_PORT};

   // Per-pin digital input enable
   for (genvar i = 0; i < 8; i++) begin : g_din
      logic cmp_hold;
      logic ref_hold;
      assign cmp_hold = CMP_SET[i] & ~s.cmp_off;
      assign ref_hold = REF_SET[i] & s.comparator_reference_output_oe;
      assign din_en[i] = port_mask[i] & ~s.analog[i] & ~cmp_hold & ~ref_hold;
   end

   always_comb begin
      setup = apb_req.psel && !apb_req.penable;
      wr_take = apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite;
      osc_code = apb_req.pwdata[`PA_OSC_W-1:0];
      mapped = 1'b1;
      rd_data = '0;
      unique case (apb_req.paddr)
         `PA_OFF_LEVEL: rd_data[7:0] = s.sync2 & din_en;
         `PA_OFF_LATCH: rd_data[7:0] = s.latch & port_mask;
         `PA_OFF_DIR: rd_data[7:0] = s.dir & port_mask;
         `PA_OFF_ANALOG: rd_data[7:0] = s.analog;
         `PA_OFF_CMP: begin
            rd_data[`PA_CMP_OFF_BIT] = s.cmp_off;
            rd_data[`PA_CMP_C1OE_BIT] = s.c1_oe;
            rd_data[`PA_CMP_C2OE_BIT] = s.c2_oe;
         end
         `PA_OFF_REF: rd_data[`PA_REF_OE_BIT] = s.comparator_reference_output_oe;
         `PA_OFF_OSC: rd_data[`PA_OSC_W-1:0] = s.osc;
         `PA_OFF_STATUS: rd_data[7:0] = ~s.pins.pin_oe_n;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      next_s = s;
      nx_port_mask = '0;
      nx_drive = '0;
      nx_value = '0;
      if (ce) begin
         // Two stages before any logic sees the pins
         next_s.sync1 = pin_in;
         next_s.sync2 = s.sync1;

         next_s.rsp.pready = 1'b0;
         next_s.rsp.pslverr = 1'b0;
         // Answer prepared in setup, so access never waits
         if (setup) begin
            next_s.rsp.pready = 1'b1;
            next_s.rsp.pslverr = !mapped;
            next_s.rsp.prdata = apb_req.pwrite ? '0 : rd_data;
         end

         // Write lands on the completing edge
         if (wr_take && apb_req.pstrb[0]) begin
            unique case (apb_req.paddr)
               // Port write goes to the latch
               `PA_OFF_LEVEL: next_s.latch = apb_req.pwdata[7:0];
               `PA_OFF_LATCH: next_s.latch = apb_req.pwdata[7:0];
               `PA_OFF_DIR: next_s.dir = apb_req.pwdata[7:0];
               `PA_OFF_ANALOG: next_s.analog = apb_req.pwdata[7:0] & `PA_ANALOG_MASK;
               `PA_OFF_CMP: begin
                  next_s.cmp_off = apb_req.pwdata[`PA_CMP_OFF_BIT];
                  next_s.c1_oe = apb_req.pwdata[`PA_CMP_C1OE_BIT];
                  next_s.c2_oe = apb_req.pwdata[`PA_CMP_C2OE_BIT];
               end
               `PA_OFF_REF: next_s.comparator_reference_output_oe = apb_req.pwdata[`PA_REF_OE_BIT];
               `PA_OFF_OSC: begin
                  // Illegal mode codes are dropped, mode kept
                  if (osc_code < `PA_OSC_COUNT) begin
                     next_s.osc = pa_osc_type'(osc_code);
                  end
               end
               default: ;
            endcase
         end

         // Pins follow the new state, not the old one
         nx_port_mask = {pin7_io(next_s.osc), pin6_io(next_s.osc), `PA_LOW_PORT};
         nx_drive = ~next_s.dir & nx_port_mask;
         // Reference output kills pin two driver
         nx_drive = nx_drive & ~(`PA_COMPARATOR_REFERENCE_OUTPUT_PIN & {8{next_s.comparator_reference_output_oe}});
         nx_value = next_s.latch;
         if (next_s.c1_oe) begin
            nx_value[`PA_PIN_T0] = comparator_one_result;
         end
         if (next_s.c2_oe) begin
            nx_value[`PA_PIN_SS] = comparator_two_result;
         end
         if (pin6_cycle_clock_output(next_s.osc)) begin
            nx_drive[`PA_PIN_CYCLE_CLOCK_OUTPUT] = 1'b1;
            nx_value[`PA_PIN_CYCLE_CLOCK_OUTPUT] = quarter_clock;
         end
         next_s.pins.pin_oe_n = ~nx_drive;
         // Undriven pins show zero to keep the bus quiet
         next_s.pins.pin_out = nx_value & nx_drive;

         next_s.t0_clk = s.sync2[`PA_PIN_T0];
         // Select only while pin five is input
         next_s.ss_n = s.dir[`PA_PIN_SS] ? s.sync2[`PA_PIN_SS] : 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s.latch <= `PA_RST_LATCH;
         s.dir <= `PA_RST_DIR;
         s.analog <= `PA_RST_ANALOG;
         s.cmp_off <= `PA_RST_CMP_OFF;
         s.c1_oe <= 1'b0;
         s.c2_oe <= 1'b0;
         s.comparator_reference_output_oe <= 1'b0;
         s.osc <= `PA_RST_OSC;
         s.sync1 <= '0;
         s.sync2 <= '0;
         s.rsp <= '0;
         s.pins.pin_out <= '0;
         s.pins.pin_oe_n <= 8'hFF;
         s.t0_clk <= 1'b0;
         s.ss_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign apb_rsp = s.rsp;
   assign pins = s.pins;
   assign timer_zero_clock_in = s.t0_clk;
   assign slave_select_in_n = s.ss_n;

endmodule

/* File: verification/pa_far.sv */
module pa_far (
   input wire pa_pkg::pa_pins_type pins,
   input wire logic [7:0] ext,
   output logic [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import pa_pkg::*;
   assign pin_in = (pins.pin_oe_n & ext) | (~pins.pin_oe_n & pins.pin_out);
endmodule

/* File: verification/pa_port_sva.sv */
`include "pa_consts.svh"
module pa_port_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire pa_pkg::pa_apb_req_type apb_req,
   input wire pa_pkg::pa_apb_rsp_type apb_rsp,
   input wire logic [7:0] pin_in,
   input wire pa_pkg::pa_pins_type pins,
   input wire logic timer_zero_clock_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import pa_pkg::*;
   logic [1:0] up;
   logic wr;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
   // Synchroniser history is junk until three edges pass
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         up <= 2'h0;
      end else if (up != 2'h3) begin
         up <= up + 2'h1;
      end
   end
   a_ready_after_setup: assert property (
      apb_req.psel && !apb_req.penable && ce |=> apb_rsp.pready) else $error("no ready");
   a_ready_one_cycle: assert property (
      apb_rsp.pready && ce |=> !apb_rsp.pready) else $error("ready too long");
   a_error_with_ready: assert property (
      apb_rsp.pslverr |-> apb_rsp.pready) else $error("lone error");
   a_undriven_low: assert property (
      (pins.pin_out & pins.pin_oe_n) == 8'h00) else $error("undriven pin high");
   a_timer_follow: assert property (
      up == 2'h3 |-> timer_zero_clock_in == $past(pin_in[4], 3)) else $error("timer lag");
   a_dir_to_drive: assert property (
      wr && apb_req.pstrb[0] && apb_req.paddr == `PA_OFF_DIR |=>
      (pins.pin_oe_n & 8'h3B) == ($past(apb_req.pwdata[7:0]) & 8'h3B)) else $error("dir");
   a_latch_to_pin: assert property (
      wr && apb_req.pstrb[0] && apb_req.paddr == `PA_OFF_LATCH |=>
      pins.pin_out[1:0] == ($past(apb_req.pwdata[1:0]) & ~pins.pin_oe_n[1:0]))
      else $error("latch");
   a_upper_zero: assert property (
      apb_rsp.pready && !apb_rsp.pslverr |-> apb_rsp.prdata[31:8] == 24'h000000)
      else $error("upper bits");
   c_dir_write: cover property (wr && apb_req.paddr == `PA_OFF_DIR);
   c_slave_error: cover property (apb_rsp.pslverr);
   c_clock_pin: cover property (!pins.pin_oe_n[6]);
endmodule
bind pa_port pa_port_chk u_pa_port_chk (.clk(clk), .rst(rst), .ce(ce), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .pin_in(pin_in), .pins(pins), .timer_zero_clock_in(timer_zero_clock_in));

/* File: verification/test_port_a_pin_control.sv */
`include "pa_consts.svh"
module test_port_a_pin_control;
   timeunit 1ns;
   timeprecision 1ps;
   import pa_pkg::*;
   logic clk, rst, c1, c2, t0, ss_n;
   logic [1:0] qn = 2'h0;
   logic [7:0] ext, pin_in, r, d;
   logic [31:0] seed = 32'hB7854E1B;
   int bad_count = 0;
   int comparisons = 0;
   logic [32:0] exp_q[$];
   pa_apb_req_type req;
   pa_apb_rsp_type rsp;
   pa_pins_type pins;
   pa_port u_pa_port (.clk(clk), .rst(rst), .ce(1'b1), .apb_req(req), .apb_rsp(rsp),
      .pin_in(pin_in), .pins(pins), .comparator_one_result(c1), .comparator_two_result(c2),
      .quarter_clock(qn[1]), .timer_zero_clock_in(t0), .slave_select_in_n(ss_n));
   pa_far u_far (.pins(pins), .ext(ext), .pin_in(pin_in));
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic check(input string n, input logic [32:0] e, input logic [32:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Reads note their expectation; writes carry data in the low word
   task automatic xfer(input logic w, input logic [11:0] a, input logic [32:0] e);
      logic ok;
      int n;
      n = 0;
      @(posedge clk);
      if (!w) exp_q.push_back(e);
      req <= '{1'b1, 1'b0, w, a, e[31:0], 4'hF};
      @(posedge clk);
      req.penable <= 1'b1;
      // Pready is judged at the rising edge, before the design updates
      do begin
         @(posedge clk);
         n++;
         ok = (rsp.pready === 1'b1);
      end while (!ok && n < 20);
      if (!ok) bad_count++;
      req <= '0;
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Error replies carry no defined data, so only the flag is judged
   always @(posedge clk) begin
      if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
         check("read", exp_q[0], {rsp.pslverr, exp_q[0][32] ? 32'h0 : rsp.prdata});
         void'(exp_q.pop_front());
      end
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) qn <= qn + 2'h1;
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   initial begin
      rst = 1'b1;
      req = '0;
      c1 = 1'b0;
      c2 = 1'b0;
      ext = 8'h00;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      ext <= rnd();
      repeat (4) @(negedge clk);
      xfer(0, `PA_OFF_ANALOG, 33'h2F);
      xfer(0, `PA_OFF_DIR, 33'hFF);
      xfer(0, `PA_OFF_LEVEL, {25'h0, ext & 8'hD0});
      r = rnd();
      d = rnd();
      xfer(1, `PA_OFF_LEVEL, {25'h0, r});
      xfer(1, `PA_OFF_DIR, {25'h0, d});
      repeat (4) @(negedge clk);
      check("pins", {17'h0, r & ~d, d}, {17'h0, pins});
      xfer(0, `PA_OFF_LATCH, {25'h0, r});
      xfer(0, `PA_OFF_LEVEL, {25'h0, ((r & ~d) | (ext & d)) & 8'hD0});
      xfer(1, `PA_OFF_ANALOG, 33'h0);
      repeat (4) @(negedge clk);
      xfer(0, `PA_OFF_LEVEL, {25'h0, (r & ~d) | (ext & d)});
      xfer(1, `PA_OFF_DIR, 33'hFF);
      for (int m = 0; m < 9; m++) begin
         xfer(1, `PA_OFF_OSC, {29'h0, m[3:0]});
         xfer(0, `PA_OFF_DIR, {25'h0, m > 6, m == 4 || m == 6 || m == 8, 6'h3F});
         @(negedge clk);
         check("clock pin", {32'h0, m == 3 || m == 5 || m == 7}, {32'h0, ~pins.pin_oe_n[6]});
      end
      r = rnd();
      @(posedge clk);
      c1 <= r[0];
      c2 <= r[1];
      xfer(1, `PA_OFF_DIR, 33'hCF);
      xfer(1, `PA_OFF_CMP, 33'h6);
      repeat (5) @(negedge clk);
      check("cmp pins", {31'h0, r[1:0]}, {31'h0, pins.pin_out[5:4]});
      check("timer select", {31'h0, r[0], 1'b1}, {31'h0, t0, ss_n});
      xfer(0, `PA_OFF_LEVEL, {25'h0, ext[7:6], r[1:0], 4'h0});
      xfer(1, `PA_OFF_DIR, 33'h0);
      xfer(1, `PA_OFF_REF, 33'h1);
      repeat (2) @(negedge clk);
      check("ref pin", 33'h1, {32'h0, pins.pin_oe_n[2]});
      xfer(1, `PA_OFF_DIR, 33'h20);
      repeat (5) @(negedge clk);
      check("select in", {32'h0, ext[5]}, {32'h0, ss_n});
      xfer(0, 12'h020, 33'h100000000);
      repeat (2) @(negedge clk);
      end_sim();
   end
endmodule
